// *** pkg/lift_seq_pkg.sv ***
/*
  constants, register map and carrier types of the lift sequencer.
  assumes a 10 MHz clock and a 32-bit classic wishbone master.
*/
// How it works
// - run rising edge closes contactor if no coast, trip, decel, and enable high.
// - with run high, coast release, trip reset or enable rise close it.
// - gate off, run drop, coast, trip, enable drop, decel: open after release delay.
// - no trigger means the contactor drive keeps its level.
// - conflicting triggers: the later one wins.
// - coast-stop and enable are active high.
// - forced-decel state lasts until command high with run and gate off.
// - input function 103 confirm differing from contactor drive trips.
// - mismatch is ignored for the check window after each drive change.
// - window keeps running past gate on when longer than startup delay.
// - gate turning on with confirm still off trips.
// - output function 78 carries door-open.
// - ref speed falling below door speed starts delay, then door-open period.
// - door delay 0.0 to 10.0 s in 0.1 s steps.
// - door period 0.1 to 30.0 s.
// - door sequence armed only by speed above door speed with door-open off.
// - battery operation uses the same door sequence.
// - door speed zero disables door-open.
// - speed in error domain for the whole detection time is an encoder error.
// - no encoder error detection in torque control.
// - mode 0 keeps running and raises function 76 fault flag.
// - modes 1 and 2 stop with a speed deviation alarm.
// - broken wiring not detected within plus or minus 0.1 Hz.
// - gate turns on only after startup delay from contactor on.
// - output function 12 carries contactor drive.
package lift_seq_pkg;
  // ******************
  // timing
  // ******************
  localparam int CLK_NS = 100;
  localparam int TICK_NS = 10_000_000;
  localparam int TICK_CYC = TICK_NS / CLK_NS;
  // ******************
  // register map
  // ******************
  localparam logic [7:0] A_WINDOW = 8'h00;
  localparam logic [7:0] A_STARTUP = 8'h04;
  localparam logic [7:0] A_RELEASE = 8'h08;
  localparam logic [7:0] A_DSPEED = 8'h0c;
  localparam logic [7:0] A_DDELAY = 8'h10;
  localparam logic [7:0] A_DPERIOD = 8'h14;
  localparam logic [7:0] A_ENCCFG = 8'h18;
  localparam logic [7:0] A_ENCTIME = 8'h1c;
  localparam logic [7:0] A_FUNC = 8'h20;
  localparam logic [7:0] A_STATUS = 8'h24;
  localparam int MODE_LSB = 0;
  localparam int LEVEL_LSB = 8;
  localparam int OUT0_LSB = 0;
  localparam int OUT1_LSB = 8;
  localparam int IN0_LSB = 16;
  // ******************
  // setting limits, hundredths or tenths of a second
  // ******************
  localparam logic [15:0] TIME_MAX = 16'h03e8;
  localparam logic [15:0] DDELAY_MAX = 16'h0064;
  localparam logic [15:0] DPERIOD_MIN = 16'h0001;
  localparam logic [15:0] DPERIOD_MAX = 16'h012c;
  localparam logic [15:0] ETIME_MAX = 16'h0064;
  localparam logic [7:0] LEVEL_MAX = 8'h32;
  localparam logic [15:0] TENTHS = 16'h000a;
  localparam logic [23:0] PERCENT = 24'h000064;
  localparam logic [15:0] ZERO_FREQ = 16'h000a;
  // ******************
  // terminal functions and reset values
  // ******************
  localparam logic [7:0] F_CONTACTOR = 8'h0c;
  localparam logic [7:0] F_ENC_FLAG = 8'h4c;
  localparam logic [7:0] F_DOOR = 8'h4e;
  localparam logic [7:0] F_CONFIRM = 8'h67;
  localparam logic [15:0] RST_TIME = 16'h0000;
  localparam logic [15:0] RST_DPERIOD = 16'h000a;
  localparam logic [1:0] M_FLAG = 2'b00;
  localparam logic [1:0] M_STOP6 = 2'b01;
  // ******************
  // types
  // ******************
  typedef enum logic [1:0] {
    D_IDLE = 2'b00,
    D_ARMED = 2'b01,
    D_DELAY = 2'b10,
    D_OPEN = 2'b11
  } door_st_t;
  typedef struct packed {
    logic run;
    logic coast_stop_cmd;
    logic enable;
    logic forced_decel_cmd;
    logic trip_ext;
    logic trip_reset;
    logic below_stop;
    logic torque_mode;
  } cmd_t;
  typedef struct packed {
    logic signed [15:0] ref_speed;
    logic signed [15:0] det_speed;
    logic signed [15:0] out_freq;
  } speed_t;
endpackage : lift_seq_pkg

// *** src/tick_timer.sv ***
/*
  one countdown timer in ticks of the shared timebase.
  assumes tick_i is a one-cycle pulse from the parent.
*/
module tick_timer
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control
  input wire logic load_i,
  input wire logic tick_i,
  input wire logic [15:0] count_i,
  // state
  output logic busy_o
);
  logic [15:0] remain;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      remain <= '0;
    else if (load_i)
      remain <= count_i;
    else if (tick_i && remain != '0)
      remain <= remain - 16'h0001;
  end

  assign busy_o = remain != '0;
endmodule : tick_timer

// *** src/lift_seq.sv ***
/*
  contactor, gate, door-open and encoder fault sequencing.
  assumes synchronous controller inputs and a classic wishbone master.
*/
// Register access over Wishbone and the register addresses were chosen for this implementation.
module lift_seq
#(
  parameter int TICK_CYCLES = lift_seq_pkg::TICK_CYC
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // elevator controller
  input wire lift_seq_pkg::cmd_t cmd_i,
  input wire lift_seq_pkg::speed_t spd_i,
  input wire logic term_in_i,
  // drive and terminals
  output logic gate_o,
  output logic trip_o,
  output logic [1:0] term_out_o
);
  // ******************
  // settings
  // ******************
  logic [15:0] window;
  logic [15:0] startup;
  logic [15:0] release_dly;
  logic [15:0] door_speed;
  logic [15:0] door_delay;
  logic [15:0] door_period;
  logic [1:0] enc_mode;
  logic [7:0] enc_level;
  logic [15:0] enc_time;
  logic [23:0] func;
  logic [16:0] tick_cnt;
  logic tick;
  logic req;
  logic [31:0] wdat;
  logic [31:0] rdat;

  // ******************
  // shared timebase
  // ******************
  always_ff @(posedge clk_i)
  begin
    if (rst_i || tick)
      tick_cnt <= '0;
    else
      tick_cnt <= tick_cnt + 17'h00001;
  end

  assign tick = tick_cnt == 17'(TICK_CYCLES - 1);

  // ******************
  // wishbone registers
  // ******************
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  always_comb
  begin
    wdat = rdat;
    for (int b = 0; b < 4; b++)
    begin
      if (wb_sel_i[b])
        wdat[b*8 +: 8] = wb_dat_i[b*8 +: 8];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      window <= lift_seq_pkg::RST_TIME;
      startup <= lift_seq_pkg::RST_TIME;
      release_dly <= lift_seq_pkg::RST_TIME;
      door_speed <= lift_seq_pkg::RST_TIME;
      door_delay <= lift_seq_pkg::RST_TIME;
      door_period <= lift_seq_pkg::RST_DPERIOD;
      enc_mode <= lift_seq_pkg::M_FLAG;
      enc_level <= '0;
      enc_time <= lift_seq_pkg::RST_TIME;
      func <= {lift_seq_pkg::F_CONFIRM, lift_seq_pkg::F_DOOR,
               lift_seq_pkg::F_CONTACTOR};
    end
    else if (req && wb_we_i)
    begin
      unique case (wb_adr_i)
        lift_seq_pkg::A_WINDOW:
          window <= (wdat[15:0] > lift_seq_pkg::TIME_MAX) ? lift_seq_pkg::TIME_MAX : wdat[15:0];
        lift_seq_pkg::A_STARTUP:
          startup <= (wdat[15:0] > lift_seq_pkg::TIME_MAX) ? lift_seq_pkg::TIME_MAX : wdat[15:0];
        lift_seq_pkg::A_RELEASE:
          release_dly <= (wdat[15:0] > lift_seq_pkg::TIME_MAX) ? lift_seq_pkg::TIME_MAX : wdat[15:0];
        lift_seq_pkg::A_DSPEED:
          door_speed <= wdat[15:0];
        lift_seq_pkg::A_DDELAY:
          door_delay <= (wdat[15:0] > lift_seq_pkg::DDELAY_MAX) ? lift_seq_pkg::DDELAY_MAX : wdat[15:0];
        lift_seq_pkg::A_DPERIOD:
          door_period <= (wdat[15:0] > lift_seq_pkg::DPERIOD_MAX) ? lift_seq_pkg::DPERIOD_MAX :
                         (wdat[15:0] < lift_seq_pkg::DPERIOD_MIN) ? lift_seq_pkg::DPERIOD_MIN : wdat[15:0];
        lift_seq_pkg::A_ENCCFG:
        begin
          enc_mode <= wdat[lift_seq_pkg::MODE_LSB +: 2];
          enc_level <= (wdat[lift_seq_pkg::LEVEL_LSB +: 8] > lift_seq_pkg::LEVEL_MAX) ?
                       lift_seq_pkg::LEVEL_MAX : wdat[lift_seq_pkg::LEVEL_LSB +: 8];
        end
        lift_seq_pkg::A_ENCTIME:
          enc_time <= (wdat[15:0] > lift_seq_pkg::ETIME_MAX) ? lift_seq_pkg::ETIME_MAX : wdat[15:0];
        lift_seq_pkg::A_FUNC:
          func <= wdat[23:0];
        default:
          ;
      endcase
    end
  end

  // ******************
  // contactor and gate
  // ******************
  logic contactor;
  logic pending;
  logic run_q;
  logic coast_q;
  logic enable_q;
  logic trip_q;
  logic fdc_q;
  logic gate_q;
  logic fd_state;
  logic trip_mis;
  logic trip_enc;
  logic trip_any;
  logic on_trig;
  logic off_trig;
  logic set_c;
  logic clr_c;
  logic start_busy;
  logic rel_busy;
  logic win_busy;
  logic confirm_used;

  assign trip_any = cmd_i.trip_ext || trip_mis || trip_enc;
  assign confirm_used = func[lift_seq_pkg::IN0_LSB +: 8] == lift_seq_pkg::F_CONFIRM;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      run_q <= 1'b0;
      coast_q <= 1'b0;
      enable_q <= 1'b0;
      trip_q <= 1'b0;
      fdc_q <= 1'b0;
      gate_q <= 1'b0;
    end
    else
    begin
      run_q <= cmd_i.run;
      coast_q <= cmd_i.coast_stop_cmd;
      enable_q <= cmd_i.enable;
      trip_q <= trip_any;
      fdc_q <= cmd_i.forced_decel_cmd;
      gate_q <= gate_o;
    end
  end

  // coast-stop and enable read straight, high means active
  assign on_trig = (cmd_i.run && !run_q && !cmd_i.coast_stop_cmd && !trip_any && cmd_i.enable && !fd_state)
                || (cmd_i.run && ((!cmd_i.coast_stop_cmd && coast_q) || (!trip_any && trip_q)
                || (cmd_i.enable && !enable_q)));

  assign off_trig = contactor && ((!gate_o && gate_q) || (!cmd_i.run && run_q && !gate_o)
                 || (cmd_i.coast_stop_cmd && !coast_q) || (trip_any && !trip_q)
                 || (!cmd_i.enable && enable_q)
                 || (cmd_i.forced_decel_cmd && !fdc_q && cmd_i.below_stop));

  assign set_c = on_trig && !off_trig && !contactor;
  assign clr_c = !off_trig && !on_trig && pending && !rel_busy;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      contactor <= 1'b0;
      pending <= 1'b0;
    end
    else if (off_trig)
      pending <= 1'b1;
    else if (on_trig)
    begin
      contactor <= 1'b1;
      pending <= 1'b0;
    end
    else if (clr_c)
    begin
      contactor <= 1'b0;
      pending <= 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      fd_state <= 1'b0;
    else if (cmd_i.forced_decel_cmd && !fdc_q)
      fd_state <= 1'b1;
    else if (cmd_i.forced_decel_cmd && !cmd_i.run && !gate_o)
      fd_state <= 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      gate_o <= 1'b0;
    else
      gate_o <= contactor && !pending && !start_busy && cmd_i.run && !trip_any
             && !cmd_i.coast_stop_cmd && cmd_i.enable;
  end

  tick_timer u_start
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .load_i(set_c),
    .tick_i(tick),
    .count_i(startup),
    .busy_o(start_busy)
  );

  tick_timer u_release
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .load_i(off_trig),
    .tick_i(tick),
    .count_i(release_dly),
    .busy_o(rel_busy)
  );

  // window runs on its own, independent of the gate
  tick_timer u_window
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .load_i(set_c || clr_c),
    .tick_i(tick),
    .count_i(window),
    .busy_o(win_busy)
  );

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      trip_mis <= 1'b0;
    else if (confirm_used && term_in_i != contactor && !win_busy && !set_c && !clr_c)
      trip_mis <= 1'b1;
    else if (confirm_used && gate_o && !gate_q && !term_in_i)
      trip_mis <= 1'b1;
    else if (cmd_i.trip_reset)
      trip_mis <= 1'b0;
  end

  // ******************
  // door-open
  // ******************
  lift_seq_pkg::door_st_t door_st;
  lift_seq_pkg::door_st_t next_door;
  logic [15:0] ref_mag;
  logic door_busy;
  logic door_load;
  logic [15:0] door_cnt;

  assign ref_mag = spd_i.ref_speed[15] ? 16'(-spd_i.ref_speed) : spd_i.ref_speed;

  always_comb
  begin
    next_door = door_st;
    door_load = 1'b0;
    door_cnt = 16'(door_delay * lift_seq_pkg::TENTHS);
    unique case (door_st)
      lift_seq_pkg::D_IDLE:
        if (ref_mag > door_speed)
          next_door = lift_seq_pkg::D_ARMED;
      lift_seq_pkg::D_ARMED:
        if (ref_mag < door_speed)
        begin
          next_door = lift_seq_pkg::D_DELAY;
          door_load = 1'b1;
        end
      lift_seq_pkg::D_DELAY:
        if (!door_busy)
        begin
          next_door = lift_seq_pkg::D_OPEN;
          door_load = 1'b1;
          door_cnt = 16'(door_period * lift_seq_pkg::TENTHS);
        end
      lift_seq_pkg::D_OPEN:
        if (!door_busy)
          next_door = lift_seq_pkg::D_IDLE;
    endcase
    if (door_speed == '0)
      next_door = lift_seq_pkg::D_IDLE;
  end

  // battery runs pass through the same path
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      door_st <= lift_seq_pkg::D_IDLE;
    else
      door_st <= next_door;
  end

  tick_timer u_door
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .load_i(door_load),
    .tick_i(tick),
    .count_i(door_cnt),
    .busy_o(door_busy)
  );

  // ******************
  // encoder fault
  // ******************
  logic [15:0] det_mag;
  logic [15:0] frq_mag;
  logic [23:0] tol;
  logic rev;
  logic over;
  logic under;
  logic broken;
  logic in_dom;
  logic enc_busy;
  logic enc_flag;

  assign det_mag = spd_i.det_speed[15] ? 16'(-spd_i.det_speed) : spd_i.det_speed;
  assign frq_mag = spd_i.out_freq[15] ? 16'(-spd_i.out_freq) : spd_i.out_freq;
  assign tol = 24'(enc_level) * 24'(ref_mag);
  assign rev = det_mag != '0 && ref_mag != '0 && spd_i.det_speed[15] != spd_i.ref_speed[15];
  assign over = det_mag > ref_mag && 24'((det_mag - ref_mag) * lift_seq_pkg::PERCENT) > tol;
  assign under = ref_mag > det_mag && 24'((ref_mag - det_mag) * lift_seq_pkg::PERCENT) > tol;
  assign broken = det_mag == '0 && ref_mag != '0 && frq_mag > lift_seq_pkg::ZERO_FREQ;
  assign in_dom = !cmd_i.torque_mode && (rev || over || broken
               || (under && det_mag != '0 && enc_mode != lift_seq_pkg::M_STOP6));

  tick_timer u_enc
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .load_i(!in_dom),
    .tick_i(tick),
    .count_i(16'(enc_time * lift_seq_pkg::TENTHS)),
    .busy_o(enc_busy)
  );

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      enc_flag <= 1'b0;
      trip_enc <= 1'b0;
    end
    else
    begin
      enc_flag <= in_dom && !enc_busy && enc_mode == lift_seq_pkg::M_FLAG;
      if (in_dom && !enc_busy && enc_mode != lift_seq_pkg::M_FLAG)
        trip_enc <= 1'b1;
      else if (cmd_i.trip_reset)
        trip_enc <= 1'b0;
    end
  end

  // ******************
  // outputs and read back
  // ******************
  always_comb
  begin
    unique case (wb_adr_i)
      lift_seq_pkg::A_WINDOW: rdat = {16'h0000, window};
      lift_seq_pkg::A_STARTUP: rdat = {16'h0000, startup};
      lift_seq_pkg::A_RELEASE: rdat = {16'h0000, release_dly};
      lift_seq_pkg::A_DSPEED: rdat = {16'h0000, door_speed};
      lift_seq_pkg::A_DDELAY: rdat = {16'h0000, door_delay};
      lift_seq_pkg::A_DPERIOD: rdat = {16'h0000, door_period};
      lift_seq_pkg::A_ENCCFG: rdat = {16'h0000, enc_level, 6'h00, enc_mode};
      lift_seq_pkg::A_ENCTIME: rdat = {16'h0000, enc_time};
      lift_seq_pkg::A_FUNC: rdat = {8'h00, func};
      lift_seq_pkg::A_STATUS: rdat = {22'h0, door_st, enc_flag, trip_enc, trip_mis,
                                      fd_state, pending, gate_o, contactor, term_in_i};
      default: rdat = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end
    else
    begin
      wb_ack_o <= req;
      if (req && !wb_we_i)
        wb_dat_o <= rdat;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      trip_o <= 1'b0;
      term_out_o <= '0;
    end
    else
    begin
      trip_o <= trip_mis || trip_enc;
      for (int i = 0; i < 2; i++)
      begin
        unique case (func[i*8 +: 8])
          lift_seq_pkg::F_CONTACTOR: term_out_o[i] <= contactor;
          lift_seq_pkg::F_DOOR: term_out_o[i] <= door_st == lift_seq_pkg::D_OPEN;
          lift_seq_pkg::F_ENC_FLAG: term_out_o[i] <= enc_flag;
          default: term_out_o[i] <= 1'b0;
        endcase
      end
    end
  end

  // ******************
  // checks
  // ******************
  contactor_on_a:
  assert property (@(posedge clk_i) disable iff (rst_i)
    (cmd_i.run && !run_q && !cmd_i.coast_stop_cmd && !trip_any && cmd_i.enable && !fd_state && !off_trig)
    |=> contactor && !pending)
    else $error("contactor not closed on run");
  release_wait_a:
  assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(contactor) |-> $past(pending) && $past(!rel_busy))
    else $error("contactor opened before release delay");
  contactor_hold_a:
  assert property (@(posedge clk_i) disable iff (rst_i)
    (!on_trig && !off_trig && !pending) |=> $stable(contactor))
    else $error("contactor changed without cause");
  gate_start_a:
  assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(gate_o) |-> $past(contactor) && $past(!start_busy))
    else $error("gate on before startup delay");
  mismatch_trip_a:
  assert property (@(posedge clk_i) disable iff (rst_i)
    (confirm_used && term_in_i != contactor && !win_busy && !set_c && !clr_c) |=> trip_mis ##1 trip_o)
    else $error("mismatch did not trip");
  gate_confirm_a:
  assert property (@(posedge clk_i) disable iff (rst_i)
    (confirm_used && gate_o && !gate_q && !term_in_i) |=> trip_mis)
    else $error("gate on with contactor open did not trip");
  fd_keep_a:
  assert property (@(posedge clk_i) disable iff (rst_i)
    (fd_state && !cmd_i.forced_decel_cmd) |=> fd_state)
    else $error("forced decel state lost");
  door_zero_a:
  assert property (@(posedge clk_i) disable iff (rst_i)
    (door_speed == '0) |=> door_st == lift_seq_pkg::D_IDLE ##1 !term_out_o[1] || func[15:8] != lift_seq_pkg::F_DOOR)
    else $error("door-open active with zero door speed");
  torque_skip_a:
  assert property (@(posedge clk_i) disable iff (rst_i)
    cmd_i.torque_mode [*2] |=> !enc_flag)
    else $error("encoder check ran in torque control");
endmodule : lift_seq

// *** verification/contactor_model.sv ***
/*
  motor contactor model: the auxiliary contact follows the coil after a lag.
  assumes the coil is driven from the sequencer's contactor output terminal.
*/
module contactor_model
#(
  parameter int LAG = 6
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // coil and welded-open fault
  input wire logic drive_i,
  input wire logic stuck_i,
  // auxiliary contact
  output logic confirm_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [LAG-1:0] sh;
  // ******************
  // mechanical lag
  // ******************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sh <= '0;
    end
    else
    begin
      sh <= {sh[LAG-2:0], drive_i};
    end
  end
  // stuck contact never closes
  assign confirm_o = stuck_i ? 1'b0 : sh[LAG-1];
endmodule : contactor_model

// *** verification/lift_seq_tb.sv ***
/*
  self-checking bench of the lift sequencer.
  assumes TICK_CYCLES of 4 and the reset terminal functions.
*/
module lift_seq_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  lift_seq_pkg::cmd_t cmd = '0;
  lift_seq_pkg::speed_t spd = '0;
  logic stuck = 1'b0;
  logic confirm;
  logic gate_o;
  logic trip_o;
  logic [1:0] term_out_o;
  logic [3:0] obs;
  logic [31:0] q;
  int bad_count = 0;
  int total_checks = 0;
  int cycles = 0;
  int c;
  assign obs = {trip_o, gate_o, term_out_o};
  always #50 clk_i = ~clk_i;
  lift_seq #(.TICK_CYCLES(4)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .cmd_i(cmd), .spd_i(spd), .term_in_i(confirm), .gate_o(gate_o), .trip_o(trip_o), .term_out_o(term_out_o));
  contactor_model model_u (.clk_i(clk_i), .rst_i(rst_i), .drive_i(term_out_o[0]), .stuck_i(stuck),
    .confirm_o(confirm));
  // ******************
  // helpers
  // ******************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1)
      @(posedge clk_i);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  // waits up to n cycles for obs[s] to reach v; c is the count spent
  task automatic wait_lvl(input int s, input logic v, input int n);
    c = 0;
    while (obs[s] !== v && c < n)
    begin
      @(posedge clk_i);
      c++;
    end
  endtask : wait_lvl
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
  endtask : step
  task automatic clear_trip;
    cmd.trip_reset <= 1'b1;
    step(1);
    cmd.trip_reset <= 1'b0;
    wait_lvl(3, 1'b0, 3);
  endtask : clear_trip
  task report_and_stop;
    $display("checks %0d errors %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop
  // ******************
  // scenarios
  // ******************
  task automatic regs;
    check("outputs", {28'h0, obs}, 32'h0);
    wb(1'b0, lift_seq_pkg::A_FUNC, 32'h0);
    check("func", q, {8'h00, lift_seq_pkg::F_CONFIRM, lift_seq_pkg::F_DOOR, lift_seq_pkg::F_CONTACTOR});
    wb(1'b0, 8'h40, 32'h0);
    check("unmapped", q, 32'h0);
    wb(1'b1, lift_seq_pkg::A_DDELAY, 32'hffff);
    wb(1'b0, lift_seq_pkg::A_DDELAY, 32'h0);
    check("ddelay_max", q, {16'h0, lift_seq_pkg::DDELAY_MAX});
    wb(1'b1, lift_seq_pkg::A_DPERIOD, 32'h0);
    wb(1'b0, lift_seq_pkg::A_DPERIOD, 32'h0);
    check("dperiod_min", q, {16'h0, lift_seq_pkg::DPERIOD_MIN});
  endtask : regs
  task automatic run_cycle;
    wb(1'b1, lift_seq_pkg::A_STARTUP, 32'h5);
    wb(1'b1, lift_seq_pkg::A_WINDOW, 32'h8);
    wb(1'b1, lift_seq_pkg::A_RELEASE, 32'h3);
    cmd.run <= 1'b1;
    wait_lvl(0, 1'b1, 4);
    check("mc_on", c, 3);
    wait_lvl(2, 1'b1, 12);
    check("gate_early", c, 12);
    wait_lvl(2, 1'b1, 20);
    check("gate_on", c < 20, 1'b1);
    check("no_trip", trip_o, 1'b0);
    cmd.run <= 1'b0;
    wait_lvl(2, 1'b0, 3);
    wait_lvl(0, 1'b0, 6);
    check("mc_hold", c, 6);
    wait_lvl(0, 1'b0, 20);
    check("mc_off", c < 20, 1'b1);
  endtask : run_cycle
  task automatic coast;
    cmd.coast_stop_cmd <= 1'b1;
    cmd.run <= 1'b1;
    wait_lvl(0, 1'b1, 10);
    check("coast_block", c, 10);
    cmd.coast_stop_cmd <= 1'b0;
    wait_lvl(0, 1'b1, 4);
    check("coast_free", c, 3);
    cmd.coast_stop_cmd <= 1'b1;
    wait_lvl(0, 1'b0, 30);
    check("coast_off", c < 30, 1'b1);
    cmd.run <= 1'b0;
    cmd.coast_stop_cmd <= 1'b0;
  endtask : coast
  task automatic mismatch;
    wb(1'b1, lift_seq_pkg::A_STARTUP, 32'h14);
    stuck <= 1'b1;
    cmd.run <= 1'b1;
    wait_lvl(0, 1'b1, 3);
    wait_lvl(3, 1'b1, 26);
    check("window", c, 26);
    wait_lvl(3, 1'b1, 20);
    check("mis_trip", c < 20, 1'b1);
    cmd.run <= 1'b0;
    wait_lvl(0, 1'b0, 30);
    check("trip_off", c < 30, 1'b1);
    stuck <= 1'b0;
    clear_trip();
  endtask : mismatch
  task automatic door;
    wb(1'b1, lift_seq_pkg::A_DSPEED, 32'h64);
    wb(1'b1, lift_seq_pkg::A_DDELAY, 32'h2);
    wb(1'b1, lift_seq_pkg::A_DPERIOD, 32'h1);
    spd.ref_speed <= 16'h0032;
    wait_lvl(1, 1'b1, 100);
    check("unarmed", c, 100);
    for (int i = 0; i < 2; i++)
    begin
      spd.ref_speed <= 16'h00c8;
      step(3);
      spd.ref_speed <= 16'h0032;
      wait_lvl(1, 1'b1, 120);
      check("door_delay", i == 0 ? (c >= 72 && c <= 92) : c == 120, 1'b1);
      wait_lvl(1, 1'b0, 60);
      check("door_period", i == 0 ? (c >= 34 && c <= 48) : c == 0, 1'b1);
      wb(1'b1, lift_seq_pkg::A_DSPEED, 32'h0);
    end
  endtask : door
  task automatic encoder;
    wb(1'b1, lift_seq_pkg::A_FUNC, {8'h00, lift_seq_pkg::F_CONFIRM, lift_seq_pkg::F_ENC_FLAG, lift_seq_pkg::F_CONTACTOR});
    wb(1'b1, lift_seq_pkg::A_ENCTIME, 32'h1);
    cmd.run <= 1'b1;
    wait_lvl(2, 1'b1, 100);
    check("enc_gate", obs[2], 1'b1);
    spd <= {16'h00c8, 16'hff38, 16'h03e8};
    wait_lvl(1, 1'b1, 60);
    check("enc_flag", c < 60, 1'b1);
    check("enc_run", trip_o, 1'b0);
    // torque control drops the flag and restarts the detection time
    cmd.torque_mode <= 1'b1;
    step(4);
    check("torque_skip", obs[1], 1'b0);
    cmd.torque_mode <= 1'b0;
    wb(1'b1, lift_seq_pkg::A_ENCCFG, {30'h0, lift_seq_pkg::M_STOP6});
    wait_lvl(3, 1'b1, 60);
    check("enc_stop", c < 60, 1'b1);
    spd <= '0;
    cmd.run <= 1'b0;
    clear_trip();
  endtask : encoder
  // ******************
  // main sequence and timeout
  // ******************
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      report_and_stop();
    end
  end
  initial
  begin
    cmd.enable <= 1'b1;
    step(2);
    rst_i <= 1'b0;
    step(1);
    regs();
    run_cycle();
    coast();
    mismatch();
    door();
    encoder();
    report_and_stop();
  end
endmodule : lift_seq_tb
